//--- logic/status_map_descriptor.sv
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Program-failure flag sits at status bit 6; descriptor encodes position as 110b.
// - Program-failure flag reads 1 only after a failed program, positive polarity.
// - Descriptor gives write opcode 00h for the status register: read only.
// - Addressed register read opcode 65h returns the addressed register contents.
// - Erase-failure flag lives in volatile status register at address 00h.
// - Erase-failure flag sits at status bit 5; descriptor encodes it as 101b.
// - Erase-failure flag reads 1 only after a failed erase, else 0.
// - Status and configuration bits are reached by addressed register commands.
// - Wait-state setting lives in nonvolatile configuration register two, address 03h.
// - Dummy cycle count before read data is host configurable, not fixed.
// - Wait-state field is 4 bits; descriptor reports width code 10b.
// - Wait-state field least significant bit is bit 0; field is bits 3:0.
// - Addressed write opcode 71h to address 03h updates the wait-state field.
// - Thirty dummy cycles are not offered; descriptor support flag reads 0.
// - Twenty-eight dummy cycles are supported; descriptor flags them with 1.
// - Wait-state code 01111b selects 28 dummy cycles on reads.
// - Program-failure flag lives in volatile status register at address 00h.
module status_map_descriptor #(
	parameter logic [3:0] WAIT_INIT = status_map_pkg::WAIT_RESET
)(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Descriptor read
	input wire logic PARAM_RD,
	input wire logic [status_map_pkg::PARAM_ADDR_WIDTH-1:0] PARAM_ADDR,
	output logic PARAM_VALID,
	output logic [7:0] PARAM_DATA,
	// Addressed register commands
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_OPCODE,
	input wire logic [7:0] CMD_REG_ADDR,
	input wire logic [7:0] CMD_WDATA,
	output logic REG_RVALID,
	output logic [7:0] REG_RDATA,
	output logic CMD_DONE,
	output logic CMD_ERR,
	// Array operation outcomes
	input wire logic PGM_DONE,
	input wire logic PGM_FAILED,
	input wire logic ERS_DONE,
	input wire logic ERS_FAILED,
	input wire logic FLAG_CLEAR,
	// Status and latency
	output logic PGM_FAIL_FLAG,
	output logic ERS_FAIL_FLAG,
	output logic [status_map_pkg::WAIT_WIDTH-1:0] WAIT_CODE,
	output logic [status_map_pkg::DUMMY_WIDTH-1:0] DUMMY_CYCLES
);

	// ****************************************************************
	// Wait-state code to dummy cycle lookup
	// ****************************************************************
	// Codes outside the supported set return zero, which callers treat as
	// unsupported; this keeps 30 cycles and the short latencies unreachable.
	function automatic logic [status_map_pkg::DUMMY_WIDTH-1:0] dummy_of(
		input logic [3:0] code
	);
		logic [status_map_pkg::DUMMY_WIDTH-1:0] cycles;
		cycles = 5'h00;
		unique case (code)
			4'h1: cycles = 5'h06;
			4'h2: cycles = 5'h08;
			4'h3: cycles = 5'h0A;
			4'h4: cycles = 5'h0C;
			4'h5: cycles = 5'h0E;
			4'h6: cycles = 5'h10;
			4'h7: cycles = 5'h12;
			4'h8: cycles = 5'h14;
			4'h9: cycles = 5'h16;
			4'hB: cycles = 5'h18;
			4'hD: cycles = 5'h1A;
			4'hF: cycles = 5'h1C;
			default: cycles = 5'h00;
		endcase
		return cycles;
	endfunction

	// ****************************************************************
	// Descriptor table
	// ****************************************************************
	function automatic logic [7:0] param_byte(
		input logic [status_map_pkg::PARAM_ADDR_WIDTH-1:0] addr
	);
		logic [7:0] value;
		value = status_map_pkg::PARAM_RESET;
		unique case (addr)
			9'h184: value = status_map_pkg::OP_READ_ONLY;
			9'h185: value = status_map_pkg::OP_REG_READ;
			9'h186: value = status_map_pkg::ADDR_STATUS_VOL;
			9'h187: value = {5'h12, status_map_pkg::PGM_FAIL_POS_CODE};
			9'h188: value = status_map_pkg::OP_READ_ONLY;
			9'h189: value = status_map_pkg::OP_REG_READ;
			9'h18A: value = status_map_pkg::ADDR_STATUS_VOL;
			9'h18B: value = {5'h12, status_map_pkg::ERS_FAIL_POS_CODE};
			9'h18C: value = status_map_pkg::OP_REG_WRITE;
			9'h18D: value = status_map_pkg::OP_REG_READ;
			9'h18E: value = status_map_pkg::ADDR_CONFIG_NV2;
			9'h18F: value = {1'b1, status_map_pkg::WAIT_WIDTH_CODE, 2'h2,
				status_map_pkg::WAIT_LSB_CODE};
			9'h190: value = status_map_pkg::OP_REG_WRITE;
			9'h191: value = status_map_pkg::OP_REG_READ;
			9'h192: value = status_map_pkg::ADDR_CONFIG_NV2;
			9'h193: value = {1'b1, status_map_pkg::WAIT_WIDTH_CODE, 2'h2,
				status_map_pkg::WAIT_LSB_CODE};
			9'h194: value = 8'hA4;
			9'h195: value = 8'h6B;
			default: value = status_map_pkg::PARAM_RESET;
		endcase
		return value;
	endfunction

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// The startup setting must itself be a supported latency
	if (dummy_of(WAIT_INIT) == 5'h00)
	begin : g_bad_wait_init
		$error("WAIT_INIT is not a supported wait-state code");
	end

	// The lookups below are written for these package values; refuse others
	if (status_map_pkg::WAIT_WIDTH != 4)
	begin : g_bad_wait_width
		$error("Wait-state field must be four bits wide");
	end

	if (status_map_pkg::WAIT_LSB + status_map_pkg::WAIT_WIDTH > 8)
	begin : g_bad_wait_span
		$error("Wait-state field must fit inside one register byte");
	end

	if (status_map_pkg::DUMMY_WIDTH < 5)
	begin : g_bad_dummy_width
		$error("Dummy cycle count needs five bits to hold 28");
	end

	if (status_map_pkg::PGM_FAIL_BIT > 7 || status_map_pkg::ERS_FAIL_BIT > 7)
	begin : g_bad_flag_bit
		$error("Failure flags must sit inside the status byte");
	end

	if (status_map_pkg::PGM_FAIL_BIT == status_map_pkg::ERS_FAIL_BIT)
	begin : g_shared_flag_bit
		$error("Program and erase failure flags need separate bits");
	end

	if (int'(status_map_pkg::PGM_FAIL_POS_CODE) != status_map_pkg::PGM_FAIL_BIT)
	begin : g_bad_pgm_code
		$error("Descriptor position code disagrees with the program flag bit");
	end

	if (int'(status_map_pkg::ERS_FAIL_POS_CODE) != status_map_pkg::ERS_FAIL_BIT)
	begin : g_bad_ers_code
		$error("Descriptor position code disagrees with the erase flag bit");
	end

	if (int'(status_map_pkg::WAIT_LSB_CODE) != status_map_pkg::WAIT_LSB)
	begin : g_bad_lsb_code
		$error("Descriptor LSB code disagrees with the wait-state field");
	end

	if (status_map_pkg::ADDR_STATUS_VOL == status_map_pkg::ADDR_CONFIG_NV2)
	begin : g_shared_reg_addr
		$error("Status and configuration registers need separate addresses");
	end

	if (status_map_pkg::PARAM_ADDR_WIDTH != 9)
	begin : g_bad_param_width
		$error("Descriptor table is decoded on nine address bits");
	end

	// ****************************************************************
	// Command decode
	// ****************************************************************
	logic is_read;
	logic is_write;
	logic hit_status;
	logic hit_config;
	logic write_ok;
	logic [7:0] next_rdata;
	logic [3:0] wr_code;

	assign is_read = CMD_VALID && (CMD_OPCODE == status_map_pkg::OP_REG_READ);
	assign is_write = CMD_VALID && (CMD_OPCODE == status_map_pkg::OP_REG_WRITE);
	assign hit_status = (CMD_REG_ADDR == status_map_pkg::ADDR_STATUS_VOL);
	assign hit_config = (CMD_REG_ADDR == status_map_pkg::ADDR_CONFIG_NV2);
	assign wr_code = CMD_WDATA[status_map_pkg::WAIT_LSB +: status_map_pkg::WAIT_WIDTH];
	// Status register is read only; unsupported latencies are refused
	assign write_ok = is_write && hit_config && (dummy_of(wr_code) != 5'h00);

	// Loaded only on a read strobe; refused reads load zero, never stale status
	always_comb
	begin
		next_rdata = 8'h00;
		if (hit_status)
		begin
			next_rdata[status_map_pkg::PGM_FAIL_BIT] = PGM_FAIL_FLAG;
			next_rdata[status_map_pkg::ERS_FAIL_BIT] = ERS_FAIL_FLAG;
		end
		else if (hit_config)
		begin
			next_rdata[status_map_pkg::WAIT_LSB +: status_map_pkg::WAIT_WIDTH] = WAIT_CODE;
		end
	end

	// ****************************************************************
	// Wait-state field
	// ****************************************************************
	// The field powers up from WAIT_INIT, standing in for the stored value
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			WAIT_CODE <= WAIT_INIT;
		else if (write_ok)
			WAIT_CODE <= wr_code;
	end

	// Latency trails the field by one edge: a read issued right after a write
	// must allow one more cycle before the new count applies
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			DUMMY_CYCLES <= 5'h00;
		else
			DUMMY_CYCLES <= dummy_of(WAIT_CODE);
	end

	// ****************************************************************
	// Failure flags
	// ****************************************************************
	// A failure reported in the clear cycle wins, so no error is lost
	// A good operation leaves a set flag alone; only the clear pulse drops it
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			PGM_FAIL_FLAG <= 1'b0;
		else if (PGM_DONE && PGM_FAILED)
			PGM_FAIL_FLAG <= 1'b1;
		else if (FLAG_CLEAR)
			PGM_FAIL_FLAG <= 1'b0;
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			ERS_FAIL_FLAG <= 1'b0;
		else if (ERS_DONE && ERS_FAILED)
			ERS_FAIL_FLAG <= 1'b1;
		else if (FLAG_CLEAR)
			ERS_FAIL_FLAG <= 1'b0;
	end

	// ****************************************************************
	// Register answers
	// ****************************************************************
	// One done pulse per strobe, so the host can pair every command with its answer
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			REG_RVALID <= 1'b0;
			REG_RDATA <= 8'h00;
			CMD_DONE <= 1'b0;
			CMD_ERR <= 1'b0;
		end
		else
		begin
			REG_RVALID <= is_read && (hit_status || hit_config);
			if (is_read)
				REG_RDATA <= next_rdata;
			CMD_DONE <= CMD_VALID;
			CMD_ERR <= CMD_VALID && !((is_read && (hit_status || hit_config)) || write_ok);
		end
	end

	// ****************************************************************
	// Descriptor answers
	// ****************************************************************
	// Pure table lookup: no device state reaches these bytes
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			PARAM_VALID <= 1'b0;
			PARAM_DATA <= status_map_pkg::PARAM_RESET;
		end
		else
		begin
			PARAM_VALID <= PARAM_RD;
			if (PARAM_RD)
				PARAM_DATA <= param_byte(PARAM_ADDR);
		end
	end

endmodule

`default_nettype wire

//--- pkg/status_map_pkg.sv
package status_map_pkg;

	// ****************************************************************
	// Register commands and addresses
	// ****************************************************************
	localparam logic [7:0] OP_REG_READ = 8'h65;
	localparam logic [7:0] OP_REG_WRITE = 8'h71;
	localparam logic [7:0] OP_READ_ONLY = 8'h00;
	localparam logic [7:0] ADDR_STATUS_VOL = 8'h00;
	localparam logic [7:0] ADDR_CONFIG_NV2 = 8'h03;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int PGM_FAIL_BIT = 6;
	localparam int ERS_FAIL_BIT = 5;
	localparam int WAIT_LSB = 0;
	localparam int WAIT_WIDTH = 4;
	localparam int DUMMY_WIDTH = 5;

	// Descriptor encodings of the same positions
	localparam logic [2:0] PGM_FAIL_POS_CODE = 3'h6;
	localparam logic [2:0] ERS_FAIL_POS_CODE = 3'h5;
	localparam logic [1:0] WAIT_WIDTH_CODE = 2'h2;
	localparam logic [2:0] WAIT_LSB_CODE = 3'h0;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [3:0] WAIT_RESET = 4'h8;
	localparam logic [7:0] PARAM_RESET = 8'h00;

	// ****************************************************************
	// Descriptor window and timing
	// ****************************************************************
	localparam int PARAM_ADDR_WIDTH = 9;
	localparam logic [8:0] PARAM_FIRST = 9'h184;
	localparam logic [8:0] PARAM_LAST = 9'h195;
	localparam int RESP_LATENCY_CYCLES = 1;

endpackage

//--- verification/host_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_ctl_model (
	// Clock
	input wire logic clk,
	// Host requests
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [7:0] cmd_reg_addr,
	output logic [7:0] cmd_wdata,
	output logic param_rd,
	output logic [8:0] param_addr
);
	initial
	begin
		{cmd_valid, param_rd, cmd_opcode, cmd_reg_addr, cmd_wdata, param_addr} = '0;
	end
	// Released fields are inverted so a stale value can never look valid
	task automatic reg_cmd(input logic [7:0] op, input logic [7:0] ra, input logic [7:0] wd);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_opcode = op;
		cmd_reg_addr = ra;
		cmd_wdata = wd;
		@(negedge clk);
		cmd_valid = 1'b0;
		{cmd_opcode, cmd_reg_addr, cmd_wdata} = ~{op, ra, wd};
	endtask
	task automatic desc_rd(input logic [8:0] a);
		@(negedge clk);
		param_rd = 1'b1;
		param_addr = a;
		@(negedge clk);
		param_rd = 1'b0;
		param_addr = ~a;
	endtask
endmodule
`default_nettype wire

//--- verification/status_map_sva.sv
`timescale 1ns/1ns
`default_nettype none
module status_map_sva (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Requests
	input wire logic PARAM_RD,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_OPCODE,
	input wire logic [7:0] CMD_REG_ADDR,
	input wire logic [7:0] CMD_WDATA,
	input wire logic PGM_DONE,
	input wire logic PGM_FAILED,
	input wire logic ERS_DONE,
	input wire logic ERS_FAILED,
	input wire logic FLAG_CLEAR,
	// Answers
	input wire logic PARAM_VALID,
	input wire logic REG_RVALID,
	input wire logic CMD_DONE,
	input wire logic CMD_ERR,
	input wire logic [7:0] REG_RDATA,
	input wire logic PGM_FAIL_FLAG,
	input wire logic ERS_FAIL_FLAG,
	input wire logic [3:0] WAIT_CODE,
	input wire logic [4:0] DUMMY_CYCLES
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_wr28;
		CMD_VALID && CMD_OPCODE == 8'h71 && CMD_REG_ADDR == 8'h03 && CMD_WDATA[3:0] == 4'hF;
	endsequence
	sequence s_set28;
		WAIT_CODE == 4'hF ##1 DUMMY_CYCLES == 5'h1C;
	endsequence
	property p_wr28; s_wr28 |=> s_set28; endproperty
	property p_desc; PARAM_RD |=> PARAM_VALID; endproperty
	property p_done; CMD_VALID |=> CMD_DONE; endproperty
	property p_ro; CMD_VALID && CMD_OPCODE == 8'h71 && CMD_REG_ADDR == 8'h00 |=> CMD_ERR; endproperty
	property p_sts;
		CMD_VALID && CMD_OPCODE == 8'h65 && CMD_REG_ADDR == 8'h00
			|=> !CMD_ERR && REG_RVALID && REG_RDATA[7] == 1'b0 && REG_RDATA[4:0] == 5'h00
			&& REG_RDATA[6] == $past(PGM_FAIL_FLAG) && REG_RDATA[5] == $past(ERS_FAIL_FLAG);
	endproperty
	property p_rd3;
		CMD_VALID && CMD_OPCODE == 8'h65 && CMD_REG_ADDR == 8'h03
			|=> REG_RVALID && !CMD_ERR && REG_RDATA == {4'h0, $past(WAIT_CODE)};
	endproperty
	property p_wbad;
		CMD_VALID && CMD_OPCODE == 8'h71 && CMD_REG_ADDR == 8'h03
			&& CMD_WDATA[3:0] inside {4'h0, 4'hA, 4'hC, 4'hE}
			|=> CMD_ERR && $stable(WAIT_CODE);
	endproperty
	property p_pset; PGM_DONE && PGM_FAILED |=> PGM_FAIL_FLAG; endproperty
	property p_eset; ERS_DONE && ERS_FAILED |=> ERS_FAIL_FLAG; endproperty
	property p_hold; PGM_FAIL_FLAG && !FLAG_CLEAR |=> PGM_FAIL_FLAG; endproperty
	property p_clr; FLAG_CLEAR && !PGM_DONE && !ERS_DONE |=> !PGM_FAIL_FLAG && !ERS_FAIL_FLAG; endproperty
	property p_wfix; !CMD_VALID |=> $stable(WAIT_CODE); endproperty
	a_wr28: assert property (p_wr28) else $error("wait code 28 not applied");
	a_desc: assert property (p_desc) else $error("descriptor answer missing");
	a_done: assert property (p_done) else $error("command answer missing");
	a_ro: assert property (p_ro) else $error("status write not refused");
	a_sts: assert property (p_sts) else $error("status read bad");
	a_pset: assert property (p_pset) else $error("program flag not set");
	a_eset: assert property (p_eset) else $error("erase flag not set");
	a_hold: assert property (p_hold) else $error("program flag lost");
	a_clr: assert property (p_clr) else $error("flags not cleared");
	a_wfix: assert property (p_wfix) else $error("wait code moved");
	a_rd3: assert property (p_rd3) else $error("config read bad");
	a_wbad: assert property (p_wbad) else $error("bad wait code accepted");
endmodule
bind status_map_descriptor status_map_sva sva_i (.REF_CLK, .RST_N, .PARAM_RD, .CMD_VALID,
	.CMD_OPCODE, .CMD_REG_ADDR, .CMD_WDATA, .PGM_DONE, .PGM_FAILED, .ERS_DONE, .ERS_FAILED,
	.FLAG_CLEAR, .PARAM_VALID, .CMD_DONE, .CMD_ERR, .REG_RDATA, .PGM_FAIL_FLAG,
	.ERS_FAIL_FLAG, .WAIT_CODE, .DUMMY_CYCLES, .REG_RVALID);
`default_nettype wire

//--- verification/tb_status_map_descriptor.sv
`timescale 1ns/1ns
`default_nettype none
module tb_status_map_descriptor;
	logic REF_CLK = 0, RST_N = 0, PGM_DONE = 0, PGM_FAILED = 0, ERS_DONE = 0, ERS_FAILED = 0;
	logic FLAG_CLEAR = 0, ep = 0, ee = 0, e;
	logic CMD_VALID, PARAM_RD, PARAM_VALID, REG_RVALID, CMD_DONE, CMD_ERR, PGM_FAIL_FLAG;
	logic ERS_FAIL_FLAG;
	logic [7:0] CMD_OPCODE, CMD_REG_ADDR, CMD_WDATA, PARAM_DATA, REG_RDATA, o, r;
	logic [8:0] PARAM_ADDR;
	logic [3:0] WAIT_CODE, w, cur = 4'h8;
	logic [4:0] DUMMY_CYCLES;
	logic [31:0] rng = 32'h0000_005C;
	int failures = 0, samples_checked = 0;
	status_map_descriptor uut (.REF_CLK, .RST_N, .PARAM_RD, .PARAM_ADDR, .PARAM_VALID,
		.PARAM_DATA, .CMD_VALID, .CMD_OPCODE, .CMD_REG_ADDR, .CMD_WDATA, .REG_RVALID,
		.REG_RDATA, .CMD_DONE, .CMD_ERR, .PGM_DONE, .PGM_FAILED, .ERS_DONE, .ERS_FAILED,
		.FLAG_CLEAR, .PGM_FAIL_FLAG, .ERS_FAIL_FLAG, .WAIT_CODE, .DUMMY_CYCLES);
	host_ctl_model hm (.clk(REF_CLK), .cmd_valid(CMD_VALID), .cmd_opcode(CMD_OPCODE),
		.cmd_reg_addr(CMD_REG_ADDR), .cmd_wdata(CMD_WDATA), .param_rd(PARAM_RD),
		.param_addr(PARAM_ADDR));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] desc(input logic [8:0] a);
		logic [7:0] t [18] = '{8'h00, 8'h65, 8'h00, 8'h96, 8'h00, 8'h65, 8'h00, 8'h95, 8'h71,
			8'h65, 8'h03, 8'hD0, 8'h71, 8'h65, 8'h03, 8'hD0, 8'hA4, 8'h6B};
		return (a >= 9'h184 && a <= 9'h195) ? t[a - 9'h184] : 8'h00;
	endfunction
	function automatic logic ok(input logic [3:0] c);
		return !(c inside {4'h0, 4'hA, 4'hC, 4'hE});
	endfunction
	function automatic logic [7:0] dum(input logic [3:0] c);
		return (c <= 4'h9) ? 8'(2 * c + 4) : 8'(c + 13);
	endfunction
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
		samples_checked++;
		if (s !== x)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		forever #2 REF_CLK = ~REF_CLK;
	end
	initial
	begin
		#20000;
		failures++;
		close_out();
	end
	initial
	begin
		repeat (5) @(negedge REF_CLK);
		RST_N = 1;
		@(negedge REF_CLK);
		chk("wait", {4'h0, status_map_pkg::WAIT_RESET}, {4'h0, WAIT_CODE});
		chk("dummy", dum(status_map_pkg::WAIT_RESET), {3'h0, DUMMY_CYCLES});
		for (int a = 9'h182; a < 9'h198; a++)
		begin
			hm.desc_rd(9'(a));
			chk("desc", desc(9'(a)), PARAM_DATA);
			chk("pvalid", 8'h01, {7'h00, PARAM_VALID});
		end
		for (int c = 15; c >= 0; c--)
		begin
			w = 4'(c);
			hm.reg_cmd(8'h71, 8'h03, {4'h0, w});
			chk("werr", {7'h00, !ok(w)}, {7'h00, CMD_ERR});
			chk("done", 8'h01, {7'h00, CMD_DONE});
			if (ok(w))
				cur = w;
			@(negedge REF_CLK);
			chk("dummy", dum(cur), {3'h0, DUMMY_CYCLES});
			hm.reg_cmd(8'h65, 8'h03, 8'h00);
			chk("cfg", {4'h0, cur}, REG_RDATA);
			chk("rvalid", 8'h01, {7'h00, REG_RVALID});
		end
		hm.reg_cmd(8'h71, 8'h00, 8'hFF);
		chk("ro", 8'h01, {7'h00, CMD_ERR});
		chk("done", 8'h01, {7'h00, CMD_DONE});
		for (int i = 0; i < 60; i++)
		begin
			rng = xs(rng);
			@(negedge REF_CLK);
			{PGM_DONE, PGM_FAILED, ERS_DONE, ERS_FAILED, FLAG_CLEAR} = rng[4:0];
			@(negedge REF_CLK);
			{PGM_DONE, PGM_FAILED, ERS_DONE, ERS_FAILED, FLAG_CLEAR} = 5'h00;
			ep = (rng[4] & rng[3]) | (ep & !rng[0]);
			ee = (rng[2] & rng[1]) | (ee & !rng[0]);
			hm.reg_cmd(8'h65, 8'h00, rng[15:8]);
			chk("rvalid", 8'h01, {7'h00, REG_RVALID});
			chk("status", {1'b0, ep, ee, 5'h00}, REG_RDATA);
			o = rng[5] ? 8'h65 : rng[15:8];
			r = rng[6] ? {6'h00, rng[7], rng[7]} : rng[23:16];
			hm.reg_cmd(o, r, 8'h00);
			e = !(o == 8'h65 && (r == 8'h00 || r == 8'h03));
			chk("err", {7'h00, e}, {7'h00, CMD_ERR});
			chk("rvalid", {7'h00, !e}, {7'h00, REG_RVALID});
			hm.desc_rd(rng[31:23]);
			chk("desc", desc(rng[31:23]), PARAM_DATA);
			chk("pvalid", 8'h01, {7'h00, PARAM_VALID});
		end
		@(negedge REF_CLK);
		RST_N = 0;
		@(negedge REF_CLK);
		chk("rst wait", {4'h0, status_map_pkg::WAIT_RESET}, {4'h0, WAIT_CODE});
		chk("rst flags", 8'h00, {6'h00, PGM_FAIL_FLAG, ERS_FAIL_FLAG});
		RST_N = 1;
		@(negedge REF_CLK);
		chk("rst dummy", dum(status_map_pkg::WAIT_RESET), {3'h0, DUMMY_CYCLES});
		hm.reg_cmd(8'h65, 8'h00, 8'h00);
		chk("rst status", 8'h00, REG_RDATA);
		close_out();
	end
endmodule
`default_nettype wire
